// File: scr_pkg.sv
package scr_pkg;

  // register addresses on the serial register port
  localparam logic [7:0] ADDR_SYS_CTRL_ONE  = 8'h2A;
  localparam logic [7:0] ADDR_SYS_CTRL_TWO  = 8'h2B;
  localparam logic [7:0] ADDR_IRQ_WAKE_CTRL = 8'h2C;

  // system_control_one fields
  localparam int C1_SLEEP_RATE_LSB = 6;
  localparam int C1_RATE_LSB       = 3;
  localparam int C1_LOW_NOISE      = 2;
  localparam int C1_FAST_READ      = 1;
  localparam int C1_ACTIVE         = 0;

  // system_control_two fields
  localparam int C2_SELF_TEST      = 7;
  localparam int C2_SOFT_RESET     = 6;
  localparam int C2_SLEEP_OS_LSB   = 3;
  localparam int C2_AUTO_SLEEP     = 2;
  localparam int C2_WAKE_OS_LSB    = 0;

  // interrupt_wake_control fields
  localparam int C3_TRANSIENT_WAKE = 6;
  localparam int C3_ORIENT_WAKE    = 5;
  localparam int C3_PULSE_WAKE     = 4;
  localparam int C3_FALL_WAKE      = 3;
  localparam int C3_IRQ_POLARITY   = 1;
  localparam int C3_IRQ_DRIVE      = 0;

  // storable bits; everything else reads zero
  localparam logic [7:0] C1_WRITE_MASK = 8'hFF;
  localparam logic [7:0] C2_WRITE_MASK = 8'h9F;
  localparam logic [7:0] C3_WRITE_MASK = 8'h7B;

  localparam logic [7:0] C1_RESET = 8'h00;
  localparam logic [7:0] C2_RESET = 8'h00;
  localparam logic [7:0] C3_RESET = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int FASTEST_PERIOD_NS   = 1250000;
  localparam int BASE_PERIOD_CYC     = FASTEST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BOOT_TIME_NS        = 64;
  localparam int BOOT_CYC            = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [2:0] scr_rate_type;

  typedef enum logic [2:0] {
    SCR_STANDBY = 3'b001,
    SCR_WAKE    = 3'b010,
    SCR_SLEEP   = 3'b100
  } scr_mode_type;

  typedef enum logic [1:0] {
    SCR_OS_NORMAL   = 2'h0,
    SCR_OS_LN_LP    = 2'h1,
    SCR_OS_HIGH_RES = 2'h2,
    SCR_OS_LOW_POW  = 2'h3
  } scr_os_type;

  // sample period in units of the fastest period
  function automatic logic [9:0] scr_rate_mult(input scr_rate_type code);
    case (code)
      3'h0:    return 10'h001;
      3'h1:    return 10'h002;
      3'h2:    return 10'h004;
      3'h3:    return 10'h008;
      3'h4:    return 10'h010;
      3'h5:    return 10'h040;
      3'h6:    return 10'h080;
      default: return 10'h200;
    endcase
  endfunction

  // samples per inactivity step at the wake rate
  function automatic logic [8:0] scr_inact_step(input scr_rate_type code);
    case (code)
      3'h0:    return 9'h100;
      3'h1:    return 9'h080;
      3'h2:    return 9'h040;
      3'h3:    return 9'h020;
      3'h4:    return 9'h010;
      3'h5:    return 9'h004;
      3'h6:    return 9'h002;
      default: return 9'h001;
    endcase
  endfunction

endpackage

// File: scr_rate_tick.sv
`timescale 1ns/10ps
module scr_rate_tick #(
  parameter int unsigned BASE_PERIOD_CYC = scr_pkg::BASE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  // rate control
  input  wire logic                 run_i,
  input  wire scr_pkg::scr_rate_type rate_i,
  // sample enable
  output logic                      tick_o
);
  import scr_pkg::*;

  localparam int unsigned BW = $clog2(BASE_PERIOD_CYC);

  typedef struct packed {
    logic [BW-1:0] base_cnt;
    logic [9:0]    mult_cnt;
    scr_rate_type  rate;
    logic          tick;
  } scr_tick_state_type;

  scr_tick_state_type state_q;
  scr_tick_state_type state_d;

  // a rate change restarts the period so no short sample slips out
  always_comb
  begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    state_d.rate = rate_i;
    if (!run_i || (rate_i != state_q.rate))
    begin
      state_d.base_cnt = '0;
      state_d.mult_cnt = '0;
    end
    else if (state_q.base_cnt == BW'(BASE_PERIOD_CYC - 1))
    begin
      state_d.base_cnt = '0;
      if (state_q.mult_cnt == (scr_rate_mult(state_q.rate) - 10'h001))
      begin
        state_d.mult_cnt = '0;
        state_d.tick     = 1'b1;
      end
      else
      begin
        state_d.mult_cnt = state_q.mult_cnt + 10'h001;
      end
    end
    else
    begin
      state_d.base_cnt = state_q.base_cnt + BW'(1);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign tick_o = state_q.tick;

endmodule

// File: scr_sys_ctrl.sv
`timescale 1ns/10ps
module scr_sys_ctrl #(
  parameter int unsigned BASE_PERIOD_CYC = scr_pkg::BASE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  // register port from the serial slave
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  output logic [7:0]                 reg_rdata_o,
  output logic                       i2c_reinit_o,
  output logic                       booting_o,
  // inactivity and detection events
  input  wire logic [7:0]            inactivity_count_i,
  input  wire logic                  transient_evt_i,
  input  wire logic                  orient_evt_i,
  input  wire logic                  pulse_evt_i,
  input  wire logic                  fall_motion_evt_i,
  // system state
  output logic                       mode_active_o,
  output logic                       sleeping_o,
  output logic                       sample_tick_o,
  output scr_pkg::scr_rate_type      output_rate_o,
  output scr_pkg::scr_rate_type      output_rate_sel_o,
  output logic [1:0]                 sleep_rate_sel_o,
  output scr_pkg::scr_os_type        active_os_o,
  // configuration
  output logic                       low_noise_sel_o,
  output logic                       fast_read_o,
  output logic                       self_test_en_o,
  output logic                       auto_sleep_en_o,
  output logic                       transient_wake_en_o,
  output logic                       orient_wake_en_o,
  output logic                       pulse_wake_en_o,
  output logic                       fall_motion_wake_en_o,
  output logic                       irq_polarity_o,
  output logic                       irq_drive_sel_o
);
  import scr_pkg::*;

  typedef struct packed {
    logic [7:0]   ctrl1;
    logic [7:0]   ctrl2;
    logic [7:0]   ctrl3;
    scr_mode_type mode;
    logic [16:0]  inact_cnt;
    logic [4:0]   boot_cnt;
    logic         booting;
    logic         reinit;
    logic [7:0]   rdata;
    scr_rate_type eff_rate;
    scr_os_type   eff_os;
  } scr_ctrl_state_type;

  scr_ctrl_state_type state_q;
  scr_ctrl_state_type state_d;
  logic               tick;
  logic [3:0]         evt;
  logic [3:0]         wake_en;
  logic               wr_ok;
  logic [16:0]        inact_target;

  assign evt     = {transient_evt_i, orient_evt_i, pulse_evt_i, fall_motion_evt_i};
  assign wake_en = {state_q.ctrl3[C3_TRANSIENT_WAKE], state_q.ctrl3[C3_ORIENT_WAKE],
                    state_q.ctrl3[C3_PULSE_WAKE], state_q.ctrl3[C3_FALL_WAKE]};
  assign wr_ok   = reg_wr_i && !state_q.booting;
  assign inact_target = 17'(inactivity_count_i) * 17'(scr_inact_step(state_q.ctrl1[5:3]));

  always_comb
  begin
    state_d        = state_q;
    state_d.reinit = 1'b0;
    // register writes; the bus is held off while booting
    if (wr_ok)
    begin
      unique case (reg_addr_i)
        ADDR_SYS_CTRL_ONE:
        begin
          if (state_q.ctrl1[C1_ACTIVE])
            state_d.ctrl1[C1_ACTIVE] = reg_wdata_i[C1_ACTIVE];
          else
            state_d.ctrl1 = reg_wdata_i & C1_WRITE_MASK;
        end
        ADDR_SYS_CTRL_TWO:
          state_d.ctrl2 = reg_wdata_i & C2_WRITE_MASK;
        ADDR_IRQ_WAKE_CTRL:
          state_d.ctrl3 = reg_wdata_i & C3_WRITE_MASK;
        default:
          state_d.ctrl1 = state_q.ctrl1;
      endcase
    end
    // register reads; reserved and reset bits were never stored
    if (reg_rd_i && !state_q.booting)
    begin
      unique case (reg_addr_i)
        ADDR_SYS_CTRL_ONE:  state_d.rdata = state_q.ctrl1;
        ADDR_SYS_CTRL_TWO:  state_d.rdata = state_q.ctrl2;
        ADDR_IRQ_WAKE_CTRL: state_d.rdata = state_q.ctrl3;
        default:            state_d.rdata = 8'h00;
      endcase
    end
    // wake and sleep sequencing
    unique case (state_q.mode)
      SCR_STANDBY:
      begin
        state_d.inact_cnt = '0;
        if (state_d.ctrl1[C1_ACTIVE])
          state_d.mode = SCR_WAKE;
      end
      SCR_WAKE:
      begin
        if (!state_d.ctrl1[C1_ACTIVE])
          state_d.mode = SCR_STANDBY;
        else if (!state_d.ctrl2[C2_AUTO_SLEEP] || (|evt))
          state_d.inact_cnt = '0;
        else if (tick)
        begin
          if ((state_q.inact_cnt + 17'h00001) >= inact_target)
          begin
            state_d.mode      = SCR_SLEEP;
            state_d.inact_cnt = '0;
          end
          else
            state_d.inact_cnt = state_q.inact_cnt + 17'h00001;
        end
      end
      SCR_SLEEP:
      begin
        if (!state_d.ctrl1[C1_ACTIVE])
          state_d.mode = SCR_STANDBY;
        else if (!state_d.ctrl2[C2_AUTO_SLEEP] || (|(evt & wake_en)))
          state_d.mode = SCR_WAKE;
      end
      default:
        state_d.mode = SCR_STANDBY;
    endcase
    // soft reset wins over everything else in the cycle
    if (wr_ok && (reg_addr_i == ADDR_SYS_CTRL_TWO) && reg_wdata_i[C2_SOFT_RESET])
    begin
      state_d.ctrl1     = C1_RESET;
      state_d.ctrl2     = C2_RESET;
      state_d.ctrl3     = C3_RESET;
      state_d.mode      = SCR_STANDBY;
      state_d.inact_cnt = '0;
      state_d.rdata     = 8'h00;
      state_d.booting   = 1'b1;
      state_d.boot_cnt  = 5'(BOOT_CYC - 1);
      state_d.reinit    = 1'b1;
    end
    else if (state_q.booting)
    begin
      if (state_q.boot_cnt == 5'h00)
        state_d.booting = 1'b0;
      else
        state_d.boot_cnt = state_q.boot_cnt - 5'h01;
    end
    // sleep rate overrides the output rate while asleep
    if (state_d.mode == SCR_SLEEP)
    begin
      state_d.eff_rate = {1'b1, state_d.ctrl1[7:6]};
      state_d.eff_os   = scr_os_type'(state_d.ctrl2[4:3]);
    end
    else
    begin
      state_d.eff_rate = state_d.ctrl1[5:3];
      state_d.eff_os   = scr_os_type'(state_d.ctrl2[1:0]);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q       <= '0;
      state_q.mode  <= SCR_STANDBY;
    end
    else
      state_q <= state_d;
  end

  // samples only run while active
  scr_rate_tick #(
    .BASE_PERIOD_CYC (BASE_PERIOD_CYC)
  ) u_rate_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (state_q.mode != SCR_STANDBY),
    .rate_i    (state_q.eff_rate),
    .tick_o    (tick)
  );

  assign reg_rdata_o           = state_q.rdata;
  assign i2c_reinit_o          = state_q.reinit;
  assign booting_o             = state_q.booting;
  assign mode_active_o         = state_q.ctrl1[C1_ACTIVE];
  assign sleeping_o            = state_q.mode[2];
  assign sample_tick_o         = tick;
  assign output_rate_o         = state_q.eff_rate;
  assign output_rate_sel_o     = state_q.ctrl1[5:3];
  assign sleep_rate_sel_o      = state_q.ctrl1[7:6];
  assign active_os_o           = state_q.eff_os;
  assign low_noise_sel_o       = state_q.ctrl1[C1_LOW_NOISE];
  assign fast_read_o           = state_q.ctrl1[C1_FAST_READ];
  assign self_test_en_o        = state_q.ctrl2[C2_SELF_TEST];
  assign auto_sleep_en_o       = state_q.ctrl2[C2_AUTO_SLEEP];
  assign transient_wake_en_o   = state_q.ctrl3[C3_TRANSIENT_WAKE];
  assign orient_wake_en_o      = state_q.ctrl3[C3_ORIENT_WAKE];
  assign pulse_wake_en_o       = state_q.ctrl3[C3_PULSE_WAKE];
  assign fall_motion_wake_en_o = state_q.ctrl3[C3_FALL_WAKE];
  assign irq_polarity_o        = state_q.ctrl3[C3_IRQ_POLARITY];
  assign irq_drive_sel_o       = state_q.ctrl3[C3_IRQ_DRIVE];

  logic soft_rst_wr;
  assign soft_rst_wr = wr_ok && (reg_addr_i == ADDR_SYS_CTRL_TWO) && reg_wdata_i[C2_SOFT_RESET];

  a_reset_standby: assert property (@(posedge ref_clk_i)
    $rose(rst_n_i) |-> !mode_active_o && !sleeping_o && (output_rate_o == 3'h0))
    else $error("not in standby after reset");

  a_active_write_guard: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_ok && (reg_addr_i == ADDR_SYS_CTRL_ONE) && mode_active_o
    |=> $stable(output_rate_sel_o) && $stable(sleep_rate_sel_o) && $stable(low_noise_sel_o))
    else $error("control one changed while active");

  a_soft_reset_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    soft_rst_wr |=> i2c_reinit_o && booting_o && !mode_active_o && !self_test_en_o
    && !irq_polarity_o && !auto_sleep_en_o)
    else $error("soft reset did not reload defaults");

  a_boot_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(booting_o) |-> booting_o [*8] ##1 booting_o [*8] ##1 !booting_o)
    else $error("boot length wrong");

  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && !booting_o && (reg_addr_i == ADDR_SYS_CTRL_TWO)
    |=> (reg_rdata_o[6:5] == 2'h0))
    else $error("reserved or reset bit read nonzero");

  a_sleep_rate_used: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sleeping_o |-> (output_rate_o == {1'b1, sleep_rate_sel_o})
    && (active_os_o == scr_os_type'(state_q.ctrl2[4:3])))
    else $error("sleep rate not applied");

  a_wake_rate_used: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !sleeping_o |-> (output_rate_o == output_rate_sel_o))
    else $error("output rate not applied");

  a_no_auto_sleep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !auto_sleep_en_o |-> !sleeping_o)
    else $error("asleep with auto-sleep off");

  a_wake_on_event: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sleeping_o && |(evt & wake_en) |=> !sleeping_o)
    else $error("enabled event did not wake");

  c_soft_reset: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) soft_rst_wr);
  c_fall_asleep: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(sleeping_o));
  c_wake_up: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $fell(sleeping_o)
    && mode_active_o);
  c_guarded_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_ok && (reg_addr_i == ADDR_SYS_CTRL_ONE) && mode_active_o);

endmodule

// File: scr_host_model.sv
`timescale 1ns/10ps
module scr_host_model (
  // clock
  input  wire logic       ref_clk_i,
  // register strobes toward the block
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  // detection events: transient, orient, pulse, fall/motion
  output logic [3:0]      evt_o
);
  import scr_pkg::*;

  initial
  begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    evt_o       = 4'h0;
  end

  // idle address and data are inverted and both strobes dropped so a stale value never passes for a live one
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    reg_wr_o    = wr;
    reg_rd_o    = ~wr;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    @(posedge ref_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask

  // fields change only from standby, the mode bit goes last
  task automatic set_ctrl_one(input logic [7:0] data);
    xfer(1'b1, ADDR_SYS_CTRL_ONE, 8'h00);
    xfer(1'b1, ADDR_SYS_CTRL_ONE, {data[7:1], 1'b0});
    if (data[0])
      xfer(1'b1, ADDR_SYS_CTRL_ONE, data);
  endtask

  task automatic pulse_evt(input logic [3:0] sel);
    @(posedge ref_clk_i);
    #1;
    evt_o = sel;
    @(posedge ref_clk_i);
    #1;
    evt_o = 4'h0;
  endtask
endmodule

// File: tb_scr_sys_ctrl.sv
`timescale 1ns/10ps
module tb_scr_sys_ctrl;
  import scr_pkg::*;
  localparam int BASE = 4;
  logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, reinit, booting, mode, sleeping, tick;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, inact;
  logic [3:0] evt;
  logic [1:0] slp_rate;
  logic ln, fr, st, asl, w_t, w_o, w_p, w_f, pol, drv;
  scr_rate_type rate, rate_sel;
  scr_os_type os;
  int n_fail = 0;
  int checks = 0;

  scr_host_model scr_host_model_inst (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .evt_o(evt));

  scr_sys_ctrl #(.BASE_PERIOD_CYC(BASE)) scr_sys_ctrl_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .i2c_reinit_o(reinit),
    .booting_o(booting), .inactivity_count_i(inact), .transient_evt_i(evt[3]),
    .orient_evt_i(evt[2]), .pulse_evt_i(evt[1]), .fall_motion_evt_i(evt[0]),
    .mode_active_o(mode), .sleeping_o(sleeping), .sample_tick_o(tick),
    .output_rate_o(rate), .output_rate_sel_o(rate_sel), .sleep_rate_sel_o(slp_rate),
    .active_os_o(os), .low_noise_sel_o(ln), .fast_read_o(fr), .self_test_en_o(st),
    .auto_sleep_en_o(asl), .transient_wake_en_o(w_t), .orient_wake_en_o(w_o),
    .pulse_wake_en_o(w_p), .fall_motion_wake_en_o(w_f), .irq_polarity_o(pol),
    .irq_drive_sel_o(drv));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    scr_host_model_inst.xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    scr_host_model_inst.xfer(1'b0, a, 8'h00);
    chk(16'(reg_rdata_o), 16'(exp));
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    while (tick !== 1'b1 && n < 3000);
  endtask

  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_reset;
    rd_chk(ADDR_SYS_CTRL_ONE, C1_RESET);
    rd_chk(ADDR_SYS_CTRL_TWO, C2_RESET);
    rd_chk(ADDR_IRQ_WAKE_CTRL, C3_RESET);
    chk(16'({mode, sleeping, rate, os, pol, drv}), 16'h0000);
  endtask

  task automatic t_rates;
    for (int i = 0; i < 8; i++)
    begin
      scr_host_model_inst.set_ctrl_one({i[1:0], i[2:0], 3'b000});
      chk(16'(rate), 16'(i));
      chk(16'(slp_rate), 16'(i[1:0]));
      chk(16'(rate_sel), 16'(i[2:0]));
      rd_chk(ADDR_SYS_CTRL_ONE, {i[1:0], i[2:0], 3'b000});
    end
    scr_host_model_inst.set_ctrl_one(8'h06);
    chk(16'({ln, fr, mode}), 16'h0006);
  endtask

  task automatic t_ctrl23;
    wr(ADDR_SYS_CTRL_TWO, 8'hBF);
    rd_chk(ADDR_SYS_CTRL_TWO, 8'h9F);
    chk(16'({st, asl}), 16'h0003);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_SYS_CTRL_TWO, 8'(k));
      chk(16'(os), 16'(k));
    end
    wr(ADDR_IRQ_WAKE_CTRL, 8'hFF);
    rd_chk(ADDR_IRQ_WAKE_CTRL, 8'h7B);
    chk(16'({w_t, w_o, w_p, w_f, pol, drv}), 16'h003F);
    wr(8'h2D, 8'hFF);
    rd_chk(8'h2D, 8'h00);
    wr(ADDR_IRQ_WAKE_CTRL, 8'h00);
    chk(16'({pol, st}), 16'h0000);
  endtask

  task automatic t_guard;
    scr_host_model_inst.set_ctrl_one(8'h09);
    wr(ADDR_SYS_CTRL_ONE, 8'hF0);
    rd_chk(ADDR_SYS_CTRL_ONE, 8'h08);
    chk(16'(mode), 16'h0000);
  endtask

  task automatic t_soft_reset;
    int n;
    scr_host_model_inst.set_ctrl_one(8'h19);
    wr(ADDR_IRQ_WAKE_CTRL, 8'h41);
    wr(ADDR_SYS_CTRL_TWO, 8'h40);
    chk(16'({reinit, booting, mode, w_t, drv, rate}), 16'h00C0);
    wr(ADDR_IRQ_WAKE_CTRL, 8'hFF);
    chk(16'(reinit), 16'h0000);
    n = 3;
    while (booting === 1'b1 && n < 40)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'd17);
    rd_chk(ADDR_SYS_CTRL_TWO, 8'h00);
    rd_chk(ADDR_IRQ_WAKE_CTRL, 8'h00);
  endtask

  task automatic t_sleep;
    int n;
    inact = 8'h01;
    wr(ADDR_SYS_CTRL_TWO, 8'h11);
    wr(ADDR_IRQ_WAKE_CTRL, 8'h40);
    scr_host_model_inst.set_ctrl_one(8'h71);
    wait_tick(n);
    wait_tick(n);
    chk(16'(n), 16'(BASE * 128));
    wait_tick(n);
    chk(16'(sleeping), 16'h0000);
    wr(ADDR_SYS_CTRL_TWO, 8'h15);
    n = 0;
    while (sleeping !== 1'b1 && n < 1600)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(16'({sleeping, rate, os}), 16'h0036);
    wait_tick(n);
    wait_tick(n);
    chk(16'(n), 16'(BASE * 64));
    scr_host_model_inst.pulse_evt(4'b0100);
    @(posedge ref_clk_i);
    #1;
    chk(16'(sleeping), 16'h0001);
    scr_host_model_inst.pulse_evt(4'b1000);
    @(posedge ref_clk_i);
    #1;
    chk(16'({sleeping, rate}), 16'h0006);
    // zero duration still needs one wake-rate sample before sleeping
    wr(ADDR_IRQ_WAKE_CTRL, 8'h10);
    inact = 8'h00;
    n = 0;
    while (sleeping !== 1'b1 && n < 1600)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(16'(sleeping), 16'h0001);
    scr_host_model_inst.pulse_evt(4'b0001);
    @(posedge ref_clk_i);
    #1;
    chk(16'(sleeping), 16'h0001);
    scr_host_model_inst.pulse_evt(4'b0010);
    @(posedge ref_clk_i);
    #1;
    chk(16'({sleeping, rate, os}), 16'h0019);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    inact   = 8'h00;
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset;
    t_rates;
    t_ctrl23;
    t_guard;
    t_soft_reset;
    t_sleep;
    final_report;
  end

  // the run needs under 8000 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    final_report;
  end
endmodule
